// *** hdl/cwb_bank.sv ***
// program-once configuration word bank with decoded outputs
// assumes a strobe register port on clk_in, read data one cycle later
module cwb_bank (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic dual_mode_in,
  input wire cwb_pkg::cwb_req_t req_in,
  output logic [23:0] rdata_out,
  output logic [7:0] written_out,
  output cwb_pkg::cwb_cfg_t cfg_out
);
  // ------------------------------------------------------------
  // storage: erased words, each bit may only go from one to zero
  // ------------------------------------------------------------
  logic [cwb_pkg::CWB_NUM_WORDS-1:0][23:0] word_reg;
  logic [cwb_pkg::CWB_NUM_WORDS-1:0] done_reg;
  logic [23:0] rdata_reg;
  cwb_pkg::cwb_cfg_t cfg_reg;
  cwb_pkg::cwb_cfg_t cfg_next;

  function automatic logic [23:0] cwb_mask(input logic [3:0] idx);
    case (idx)
      cwb_pkg::CWB_ADDR_DIS: cwb_mask = ~cwb_pkg::CWB_DIS_ONES;
      cwb_pkg::CWB_ADDR_OPT: cwb_mask = cwb_pkg::CWB_OPT_MASK;
      cwb_pkg::CWB_ADDR_SETS: cwb_mask = cwb_pkg::CWB_SETS_MASK;
      cwb_pkg::CWB_ADDR_CNT_LO, cwb_pkg::CWB_ADDR_CNT_HI: cwb_mask = 24'h00ffff;
      default: cwb_mask = 24'hffffff;
    endcase
  endfunction

  wire [cwb_pkg::CWB_NUM_WORDS-1:0] prog_hit;
  wire [cwb_pkg::CWB_NUM_WORDS-1:0][23:0] prog_val;

  genvar gi;
  generate
    for (gi = 0; gi < cwb_pkg::CWB_NUM_WORDS; gi++) begin : g_word
      // one programming pass per word, bits only clear
      assign prog_hit[gi] = req_in.wr && (req_in.addr == 4'(gi)) && !done_reg[gi];
      assign prog_val[gi] = word_reg[gi] & (req_in.wdata | ~cwb_mask(4'(gi)));
    end
  endgenerate

  // one process owns the whole bank, so each word has a single driver
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      word_reg <= {cwb_pkg::CWB_NUM_WORDS{cwb_pkg::CWB_ERASED}};
      done_reg <= '0;
    end else begin
      for (int i = 0; i < cwb_pkg::CWB_NUM_WORDS; i++) begin
        if (prog_hit[i]) begin
          word_reg[i] <= prog_val[i];
          done_reg[i] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  wire [23:0] w_lo = word_reg[cwb_pkg::CWB_ADDR_CNT_LO];
  wire [23:0] w_hi = word_reg[cwb_pkg::CWB_ADDR_CNT_HI];
  wire [23:0] w_dis = word_reg[cwb_pkg::CWB_ADDR_DIS] | cwb_pkg::CWB_DIS_ONES; // [R04]
  wire [23:0] w_opt = word_reg[cwb_pkg::CWB_ADDR_OPT];
  wire [23:0] w_sets = word_reg[cwb_pkg::CWB_ADDR_SETS] | ~cwb_pkg::CWB_SETS_MASK; // [R07]
  wire [23:0] w_sa = word_reg[cwb_pkg::CWB_ADDR_SEQ_A];
  wire [23:0] w_sb = word_reg[cwb_pkg::CWB_ADDR_SEQ_B];
  wire [11:0] seq_a = w_sa[cwb_pkg::CWB_SEQ_LSB +: cwb_pkg::CWB_SEQ_W]; // [R08]
  wire [11:0] seq_b = w_sb[cwb_pkg::CWB_SEQ_LSB +: cwb_pkg::CWB_SEQ_W];
  // inverse field written by the programmer [R09]
  wire [11:0] inv_a = w_sa[cwb_pkg::CWB_INV_LSB +: cwb_pkg::CWB_SEQ_W];
  wire [11:0] inv_b = w_sb[cwb_pkg::CWB_INV_LSB +: cwb_pkg::CWB_SEQ_W];
  wire ok_a = (inv_a == ~seq_a); // [R10]
  wire ok_b = (inv_b == ~seq_b); // [R10]
  wire pick_b = ok_b && (!ok_a || (seq_b < seq_a)); // [R08]
  wire [3:0] set_assigned;
  wire [3:0][2:0] set_level;

  generate
    for (gi = 0; gi < cwb_pkg::CWB_NUM_SETS; gi++) begin : g_set
      cwb_level_map u_map (
        .field_in(w_sets[gi*cwb_pkg::CWB_LVL_STRIDE +: cwb_pkg::CWB_LVL_W]), // [R07]
        .assigned_out(set_assigned[gi]),
        .level_out(set_level[gi])
      );
    end
  endgenerate

  always_comb begin
    cfg_next = '0;
    cfg_next.instr_count_timeout = {w_hi[cwb_pkg::CWB_HALF_LSB +: cwb_pkg::CWB_HALF_W], // [R02]
                                    w_lo[cwb_pkg::CWB_HALF_LSB +: cwb_pkg::CWB_HALF_W]}; // [R01]
    cfg_next.deadman_off = w_dis[cwb_pkg::CWB_DIS_BIT]; // [R03]
    cfg_next.spi_two_pin_route = w_opt[cwb_pkg::CWB_SPI_BIT]; // [R05]
    cfg_next.set_assigned = set_assigned;
    cfg_next.interrupt_priority_level = set_level;
    cfg_next.active_partition = dual_mode_in ? pick_b : 1'b0; // [R08]
    cfg_next.partition_valid = dual_mode_in ? (ok_a || ok_b) : 1'b1;
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  logic [23:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[cwb_pkg::CWB_ST_PART_BIT] = cfg_reg.active_partition; // [R08]
    status_word[cwb_pkg::CWB_ST_VA_BIT] = ok_a; // [R10]
    status_word[cwb_pkg::CWB_ST_VB_BIT] = ok_b; // [R10]
    status_word[cwb_pkg::CWB_ST_DIS_BIT] = cfg_reg.deadman_off; // [R03]
  end
  logic [23:0] rd_sel;
  always_comb begin
    case (req_in.addr)
      cwb_pkg::CWB_ADDR_CNT_LO: rd_sel = w_lo | ~cwb_mask(cwb_pkg::CWB_ADDR_CNT_LO);
      cwb_pkg::CWB_ADDR_CNT_HI: rd_sel = w_hi | ~cwb_mask(cwb_pkg::CWB_ADDR_CNT_HI);
      cwb_pkg::CWB_ADDR_DIS: rd_sel = w_dis; // [R04]
      cwb_pkg::CWB_ADDR_OPT: rd_sel = w_opt | ~cwb_pkg::CWB_OPT_MASK;
      cwb_pkg::CWB_ADDR_SETS: rd_sel = w_sets;
      cwb_pkg::CWB_ADDR_SEQ_A: rd_sel = w_sa;
      cwb_pkg::CWB_ADDR_SEQ_B: rd_sel = w_sb;
      cwb_pkg::CWB_ADDR_STATUS: rd_sel = status_word;
      default: rd_sel = 24'h000000;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= 24'h000000;
      cfg_reg <= '0;
    end else begin
      rdata_reg <= req_in.rd ? rd_sel : 24'h000000;
      cfg_reg <= cfg_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign written_out = {1'b0, done_reg};
  assign cfg_out = cfg_reg;
endmodule

// *** hdl/cwb_level_map.sv ***
// decodes one 3-bit register set field into a priority level
// assumes the field is a stable configuration value
module cwb_level_map (
  input wire logic [2:0] field_in,
  output logic assigned_out,
  output logic [2:0] level_out
);
  // ------------------------------------------------------------
  // 000..110 map to levels 1..7, 111 unassigned
  // ------------------------------------------------------------
  assign assigned_out = (field_in != cwb_pkg::CWB_LVL_NONE); // [R06]
  assign level_out = assigned_out ? 3'(field_in + 3'h1) : 3'h0; // [R06]
endmodule

// *** shared/cwb_pkg.sv ***
// package of constants and carrier types for the configuration word bank
// assumes a single 50 MHz clock domain and a plain strobe register port
//
// Contract
// R01: timeout low half from low word bits 15-0
// R02: timeout high half from high word bits
// R03: deadman off bit one disables the timer
// R04: disable word bits 23-1 read as ones
// R05: spi two route bit picks remap or fixed
// R06: level codes 000-110 map levels 1-7, 111 unassigned
// R07: four level fields at bits 2,6,10,14 upward; the bank takes them at bits 0,4,8,12 upward
// R08: lower valid boot number picks active partition
// R09: programmer writes inverse boot number bits 23-12
// R10: boot number valid only when inverse matches
package cwb_pkg;
  // ------------------------------------------------------------
  // word indices and address map
  // ------------------------------------------------------------
  localparam int unsigned CWB_WORD_W = 24;
  localparam int unsigned CWB_ADDR_W = 4;
  localparam logic [3:0] CWB_ADDR_CNT_LO = 4'h0;
  localparam logic [3:0] CWB_ADDR_CNT_HI = 4'h1;
  localparam logic [3:0] CWB_ADDR_DIS = 4'h2;
  localparam logic [3:0] CWB_ADDR_OPT = 4'h3;
  localparam logic [3:0] CWB_ADDR_SETS = 4'h4;
  localparam logic [3:0] CWB_ADDR_SEQ_A = 4'h5;
  localparam logic [3:0] CWB_ADDR_SEQ_B = 4'h6;
  localparam logic [3:0] CWB_ADDR_STATUS = 4'h7;
  localparam int unsigned CWB_NUM_WORDS = 7;
  // ------------------------------------------------------------
  // field positions and erased values
  // ------------------------------------------------------------
  localparam logic [23:0] CWB_ERASED = 24'hffffff;
  localparam int unsigned CWB_HALF_LSB = 0;
  localparam int unsigned CWB_HALF_W = 16;
  localparam int unsigned CWB_DIS_BIT = 0;
  localparam int unsigned CWB_SPI_BIT = 13;
  localparam logic [23:0] CWB_DIS_ONES = 24'hfffffe;
  localparam logic [23:0] CWB_OPT_MASK = 24'h002000;
  localparam logic [23:0] CWB_SETS_MASK = 24'h007777;
  localparam int unsigned CWB_LVL_W = 3;
  localparam int unsigned CWB_LVL_STRIDE = 4;
  localparam int unsigned CWB_NUM_SETS = 4;
  localparam logic [2:0] CWB_LVL_NONE = 3'h7;
  localparam int unsigned CWB_SEQ_W = 12;
  localparam int unsigned CWB_SEQ_LSB = 0;
  localparam int unsigned CWB_INV_LSB = 12;
  localparam int unsigned CWB_ST_PART_BIT = 0;
  localparam int unsigned CWB_ST_VA_BIT = 1;
  localparam int unsigned CWB_ST_VB_BIT = 2;
  localparam int unsigned CWB_ST_DIS_BIT = 3;

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [CWB_ADDR_W-1:0] addr;
    logic [CWB_WORD_W-1:0] wdata;
    logic wr;
    logic rd;
  } cwb_req_t;

  typedef struct packed {
    logic [31:0] instr_count_timeout;
    logic deadman_off;
    logic spi_two_pin_route;
    logic [3:0] set_assigned;
    logic [3:0][2:0] interrupt_priority_level;
    logic active_partition;
    logic partition_valid;
  } cwb_cfg_t;
endpackage

// *** verification/config_word_bank_bench.sv ***
// bench for the configuration word bank
// assumes cwb_bank with strobe port, read data one cycle after rd
module config_word_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, nrst_in, dual_mode_in;
  cwb_pkg::cwb_req_t req;
  cwb_pkg::cwb_cfg_t cfg;
  logic [23:0] rdata_out, boot_word, q;
  logic [7:0] written_out;
  logic [11:0] seq;
  int err_count, tests_run;
  cwb_bank dut (.clk_in(clk_in), .nrst_in(nrst_in), .dual_mode_in(dual_mode_in), .req_in(req),
    .rdata_out(rdata_out), .written_out(written_out), .cfg_out(cfg));
  cwb_programmer prog (.seq_in(seq), .word_out(boot_word));
  // ------------------------------------------------------------
  // clock and tasks
  // ------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk_in);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_in);
    req <= '{a, 24'h0, 1'b0, 1'b1};
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1;
    q = rdata_out;
  endtask
  task automatic settle;
    @(posedge clk_in);
    #1;
  endtask
  task automatic do_reset;
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
  endtask
  task automatic close_out;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    req = '0;
    nrst_in = 1'b0;
    dual_mode_in = 1'b1;
    seq = 12'h005;
    err_count = 0;
    tests_run = 0;
    do_reset;
    settle;
    chk("erased timeout", 32'hffffffff, cfg.instr_count_timeout);
    chk("erased deadman off", 32'h1, {31'h0, cfg.deadman_off});
    chk("erased spi route", 32'h1, {31'h0, cfg.spi_two_pin_route});
    wr(4'h0, 24'h001234);
    wr(4'h1, 24'h00abcd);
    wr(4'h0, 24'h000000);
    settle;
    chk("timeout", 32'habcd1234, cfg.instr_count_timeout);
    rd(4'h0);
    chk("low word", 32'hff1234, {8'h0, q});
    wr(4'h2, 24'h000000);
    wr(4'h3, 24'h000000);
    settle;
    chk("deadman off", 32'h0, {31'h0, cfg.deadman_off});
    chk("spi route", 32'h0, {31'h0, cfg.spi_two_pin_route});
    rd(4'h2);
    chk("disable word", 32'hfffffe, {8'h0, q});
    wr(4'h5, boot_word);
    seq = 12'h003;
    settle;
    wr(4'h6, boot_word);
    settle;
    chk("partition", 32'h1, {31'h0, cfg.active_partition});
    chk("partition valid", 32'h1, {31'h0, cfg.partition_valid});
    rd(4'h7);
    chk("status", 32'h7, {28'h0, q[3:0]});
    rd(4'h8);
    chk("unmapped", 32'h0, {8'h0, q});
    dual_mode_in <= 1'b0;
    repeat (2) settle;
    chk("single mode", 32'h0, {31'h0, cfg.active_partition});
    chk("single mode valid", 32'h1, {31'h0, cfg.partition_valid});
    chk("written", 32'h6f, {24'h0, written_out});
    rd(4'h3);
    chk("option word", 32'hffdfff, {8'h0, q});
    for (int c = 0; c < 8; c++) begin
      dual_mode_in <= 1'b1;
      seq = 12'h009;
      do_reset;
      wr(4'h5, boot_word);
      wr(4'h6, 24'h000003);
      wr(4'h4, {8'h00, 1'b0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]});
      settle;
      chk("levels", {20'h0, {4{c == 7 ? 3'h0 : c[2:0] + 3'h1}}}, {20'h0, cfg.interrupt_priority_level});
      chk("assigned", {28'h0, {4{c != 7}}}, {28'h0, cfg.set_assigned});
      chk("bad inverse", 32'h0, {31'h0, cfg.active_partition});
      chk("one valid", 32'h1, {31'h0, cfg.partition_valid});
    end
    do_reset;
    wr(4'h5, 24'h000005);
    settle;
    chk("both invalid", 32'h0, {31'h0, cfg.partition_valid});
    close_out;
  end
endmodule

// *** verification/cwb_bank_asserts.sv ***
// port checker for the configuration word bank
// assumes cwb_bank ports, one clock, cfg one cycle after word change
module cwb_bank_asserts (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic dual_mode_in,
  input wire cwb_pkg::cwb_req_t req_in,
  input wire logic [23:0] rdata_out,
  input wire logic [7:0] written_out,
  input wire cwb_pkg::cwb_cfg_t cfg_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  chk_count_low: assert property (req_in.wr && req_in.addr == 4'h0 && !written_out[0] |=> ##1
    cfg_out.instr_count_timeout[15:0] == $past(req_in.wdata[15:0], 2)) else $error("timeout low wrong");
  chk_count_high: assert property (req_in.wr && req_in.addr == 4'h1 && !written_out[1] |=> ##1
    cfg_out.instr_count_timeout[31:16] == $past(req_in.wdata[15:0], 2)) else $error("timeout high wrong");
  chk_deadman_off: assert property (req_in.wr && req_in.addr == 4'h2 && !written_out[2] |=> ##1
    cfg_out.deadman_off == $past(req_in.wdata[0], 2)) else $error("deadman off wrong");
  chk_disable_ones: assert property (req_in.rd && req_in.addr == 4'h2 |=>
    rdata_out[23:1] == 23'h7fffff) else $error("disable word upper bits not ones");
  chk_spi_route: assert property (req_in.wr && req_in.addr == 4'h3 && !written_out[3] |=> ##1
    cfg_out.spi_two_pin_route == $past(req_in.wdata[13], 2)) else $error("spi route wrong");
  chk_level_code: assert property (req_in.wr && req_in.addr == 4'h4 && !written_out[4] |=> ##1
    cfg_out.interrupt_priority_level[0] == ($past(req_in.wdata[2:0], 2) == 3'h7 ? 3'h0 :
    $past(req_in.wdata[2:0], 2) + 3'h1)) else $error("set one level wrong");
  chk_set_four: assert property (req_in.wr && req_in.addr == 4'h4 && !written_out[4] |=> ##1
    cfg_out.set_assigned[3] == ($past(req_in.wdata[14:12], 2) != 3'h7)) else $error("set four wrong");
  chk_single_part: assert property (!dual_mode_in [*2] |->
    !cfg_out.active_partition && cfg_out.partition_valid) else $error("single mode partition wrong");
endmodule

bind cwb_bank cwb_bank_asserts u_chk (.clk_in(clk_in), .nrst_in(nrst_in), .dual_mode_in(dual_mode_in),
  .req_in(req_in), .rdata_out(rdata_out), .written_out(written_out), .cfg_out(cfg_out));

// *** verification/cwb_programmer.sv ***
// programmer model building a boot sequence word
// assumes the bench writes the word once
module cwb_programmer (
  input wire logic [11:0] seq_in,
  output logic [23:0] word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // inverse number above the boot number
  // ------------------------------------------------------------
  assign word_out = {~seq_in, seq_in};
endmodule
